// *** core/sync_serial_rx_and_duplex.sv ***
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "sio_defs.svh"
// How it works
// - missing tx data at ext shift start: underrun, irq
// - underrun holds serial output high
// - force stop resets flags, buffers and counters at once
// - mode 01 receive, 10 full duplex
// - active flag rises on clock falling edge
// - receive samples input on rising edges
// - shift flag from first fall to eighth rise
// - full byte to receive buffer, flag, irq
// - internal clock starts within one period
// - rx read clears full; tx write clears empty
// - internal receive parks clock until read
// - ext clock unread byte gives overrun, irq
// - overrun freezes buffer and shift register
// - after overrun and stop clear, second read returns shift register
// - stop clear needs eight more clocks after overrun
// - overrun suppresses further irqs
// - stop clear finishes byte, output high
// - duplex drives on fall, samples on rise
// - duplex empty on rise after load, irq with full
// - duplex internal parks until read and write
// - duplex underrun irq after full byte
// - mode 00 transmit only
// - order 0 msb first, 1 lsb first
// - clock select 111 takes external clock
module sync_serial_rx_and_duplex
   import sio_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial link
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe,
   input wire logic serial_in_line,
   output logic serial_out_line,
   // event
   output logic serial_port_irq
);
   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
      shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   // control and status
   logic start_request_q, start_request_d;
   logic bit_order_q, bit_order_d;
   logic [1:0] transfer_mode_field_q, transfer_mode_field_d;
   logic [2:0] cksel_q, cksel_d;
   logic shift_active_flag_q, shift_active_flag_d;
   logic transfer_active_flag_q, transfer_active_flag_d;
   logic receive_full_flag_q, receive_full_flag_d;
   logic transmit_empty_flag_q, transmit_empty_flag_d;
   logic receive_overrun_flag_q, receive_overrun_flag_d;
   logic transmit_underrun_flag_q, transmit_underrun_flag_d;
   logic [7:0] transmit_buffer_q, transmit_buffer_d;
   logic [7:0] receive_buffer_q, receive_buffer_d;
   logic [7:0] shreg_q, shreg_d;
   logic [3:0] bitcnt_q, bitcnt_d;
   logic rx_read_q, rx_read_d;
   logic tx_written_q, tx_written_d;
   logic second_read_q, second_read_d;
   logic [3:0] drain_q, drain_d;
   logic irq_pend_q, irq_pend_d;
   logic irq_q, irq_d;
   logic out_q, out_d;
   link_state_e state_q, state_d;
   // internal clock generator
   logic [7:0] div_q, div_d;
   logic sck_int_q, sck_int_d;
   // pin synchroniser
   logic [1:0] sck_sync_q;
   logic [1:0] si_sync_q;
   logic sck_prev_q;

   logic ext, wr, rd, run_mode, fall, rise, tx_mode, rx_mode;
   logic [31:0] status_word;

   assign ext = (cksel_q == `CKSEL_EXT);
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign tx_mode = (transfer_mode_field_q == `MODE_TX) ||
      (transfer_mode_field_q == `MODE_DUPLEX);
   assign rx_mode = (transfer_mode_field_q == `MODE_RX) ||
      (transfer_mode_field_q == `MODE_DUPLEX);
   assign run_mode = tx_mode || rx_mode;

   // edge finding on the selected clock, ext goes through two flops first
   logic sck_now;
   assign sck_now = ext ? sck_sync_q[1] : sck_int_q;
   assign fall = sck_prev_q && !sck_now;
   assign rise = !sck_prev_q && sck_now;

   assign status_word = {26'h0000000, transmit_underrun_flag_q, receive_overrun_flag_q,
      transmit_empty_flag_q, receive_full_flag_q, transfer_active_flag_q,
      shift_active_flag_q};

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign serial_clock_pin_o = sck_int_q;
   assign serial_clock_pin_oe = !ext;
   assign serial_out_line = out_q;
   assign serial_port_irq = irq_q;

   always_comb begin
      logic go;
      go = 1'b0;
      start_request_d = start_request_q;
      bit_order_d = bit_order_q;
      transfer_mode_field_d = transfer_mode_field_q;
      cksel_d = cksel_q;
      shift_active_flag_d = shift_active_flag_q;
      transfer_active_flag_d = transfer_active_flag_q;
      receive_full_flag_d = receive_full_flag_q;
      transmit_empty_flag_d = transmit_empty_flag_q;
      receive_overrun_flag_d = receive_overrun_flag_q;
      transmit_underrun_flag_d = transmit_underrun_flag_q;
      transmit_buffer_d = transmit_buffer_q;
      receive_buffer_d = receive_buffer_q;
      shreg_d = shreg_q;
      bitcnt_d = bitcnt_q;
      rx_read_d = rx_read_q;
      tx_written_d = tx_written_q;
      second_read_d = second_read_q;
      drain_d = drain_q;
      irq_pend_d = irq_pend_q;
      irq_d = 1'b0;
      out_d = out_q;
      state_d = state_q;
      div_d = div_q;
      sck_int_d = sck_int_q;
      prdata = 32'h00000000;

      // register reads
      if (psel && !pwrite) begin
         case (paddr)
            `REG_CONTROL: prdata = {24'h000000, cksel_q, transfer_mode_field_q, bit_order_q,
               1'b0, start_request_q};
            `REG_STATUS: prdata = status_word;
            `REG_TXBUF: prdata = {24'h000000, transmit_buffer_q};
            `REG_RXBUF: prdata = {24'h000000, second_read_q ? shreg_q : receive_buffer_q};
            default: prdata = 32'h00000000;
         endcase
      end

      // internal clock generator: runs only while a byte is moving
      if (state_q == st_run && !ext) begin
         if (div_q == `HALF_DIV_DEFAULT - 8'h01) begin
            div_d = 8'h00;
            sck_int_d = !sck_int_q;
         end else begin
            div_d = div_q + 8'h01;
         end
      end else begin
         div_d = 8'h00;
         sck_int_d = 1'b1;
      end

      // link state machine
      case (state_q)
         st_idle: begin
            if (start_request_q && run_mode) begin
               // internal clock waits for data in transmit modes
               if (ext || !tx_mode || !transmit_empty_flag_q) begin
                  state_d = st_run;
               end
            end
         end
         st_run: begin
            if (fall && bitcnt_q < 4'h8) begin
               if (bitcnt_q == 4'h0) begin
                  go = 1'b1;
                  transfer_active_flag_d = 1'b1;
                  shift_active_flag_d = 1'b1;
                  if (tx_mode) begin
                     if (transmit_empty_flag_q) begin
                        transmit_underrun_flag_d = 1'b1;
                        if (transfer_mode_field_q == `MODE_TX) begin
                           irq_pend_d = 1'b1;
                        end
                     end else begin
                        shreg_d = transmit_buffer_q;
                        tx_written_d = 1'b0;
                     end
                  end
               end
               if (tx_mode) begin
                  // drive on fall
                  out_d = (transmit_underrun_flag_q || transmit_underrun_flag_d) ? 1'b1 :
                     (bit_order_q ? shreg_d[0] : shreg_d[7]);
               end
               bitcnt_d = bitcnt_q + 4'h1;
            end
            if (fall && irq_pend_q) begin
               irq_pend_d = 1'b0;
               irq_d = !receive_overrun_flag_q;
            end
            if (rise && bitcnt_q != 4'h0) begin
               if (bitcnt_q == 4'h1 && tx_mode && !transmit_underrun_flag_q) begin
                  transmit_empty_flag_d = 1'b1;
               end
               // shared register: outgoing bit always sits at the end being shifted out
               if (run_mode && !receive_overrun_flag_q) begin
                  shreg_d = shift_in(shreg_q, si_sync_q[1], bit_order_q);
               end
               if (drain_q != 4'h0) begin
                  drain_d = drain_q - 4'h1;
               end
               if (bitcnt_q == 4'h8) begin
                  bitcnt_d = 4'h0;
                  shift_active_flag_d = 1'b0;
                  if (rx_mode && !receive_overrun_flag_q) begin
                     if (receive_full_flag_q && ext) begin
                        receive_overrun_flag_d = 1'b1;
                        irq_d = 1'b1;
                     end else begin
                        receive_buffer_d = shreg_d;
                        receive_full_flag_d = 1'b1;
                        irq_d = 1'b1;
                        rx_read_d = 1'b0;
                     end
                  end else if (transfer_mode_field_q == `MODE_TX && !receive_overrun_flag_q
                     && !transmit_underrun_flag_q) begin
                     irq_d = 1'b1;
                  end
                  if (transfer_mode_field_q == `MODE_DUPLEX && transmit_underrun_flag_q) begin
                     irq_d = !receive_overrun_flag_q;
                  end
                  if (!start_request_q && drain_q == 4'h0) begin
                     state_d = st_idle;
                     transfer_active_flag_d = 1'b0;
                     out_d = 1'b1;
                  end else if (!ext) begin
                     state_d = st_wait;
                  end
               end
            end
            if (receive_overrun_flag_q && !start_request_q && drain_q == 4'h0 &&
               bitcnt_q == 4'h0) begin
               state_d = st_idle;
               transfer_active_flag_d = 1'b0;
            end
         end
         st_wait: begin
            // auto wait: clock parked high
            if (!start_request_q) begin
               state_d = st_idle;
               transfer_active_flag_d = 1'b0;
               out_d = 1'b1;
            end else if (transfer_mode_field_q == `MODE_RX && rx_read_q) begin
               state_d = st_run;
            end else if (transfer_mode_field_q == `MODE_DUPLEX && rx_read_q &&
               tx_written_q) begin
               state_d = st_run;
            end else if (transfer_mode_field_q == `MODE_TX && tx_written_q) begin
               state_d = st_run;
            end
         end
         default: state_d = st_idle;
      endcase

      // register writes and read side effects
      if (rd && paddr == `REG_RXBUF) begin
         receive_full_flag_d = receive_full_flag_d && !receive_full_flag_q;
         rx_read_d = rx_read_d || receive_full_flag_q;
         if (receive_overrun_flag_q && !start_request_q) begin
            second_read_d = 1'b1;
         end
      end
      if (wr) begin
         case (paddr)
            `REG_CONTROL: begin
               bit_order_d = pwdata[`CTL_ORDER];
               transfer_mode_field_d = pwdata[`CTL_MODE_LO+1:`CTL_MODE_LO];
               cksel_d = pwdata[`CTL_CKSEL_LO+2:`CTL_CKSEL_LO];
               if (start_request_q && !pwdata[`CTL_START] && receive_overrun_flag_q) begin
                  drain_d = 4'h8;
               end
               start_request_d = pwdata[`CTL_START];
            end
            `REG_STATUS: begin
               // write 0 clears overrun, and full with it
               if (!pwdata[`ST_OVERRUN] && receive_overrun_flag_q) begin
                  receive_overrun_flag_d = 1'b0;
                  receive_full_flag_d = 1'b0;
                  second_read_d = 1'b0;
               end
            end
            `REG_TXBUF: begin
               transmit_buffer_d = pwdata[7:0];
               transmit_empty_flag_d = go ? transmit_empty_flag_d : 1'b0;
               tx_written_d = 1'b1;
            end
            default: ;
         endcase
      end

      // force stop wins over everything
      if (wr && paddr == `REG_CONTROL && pwdata[`CTL_STOP]) begin
         start_request_d = 1'b0;
         shift_active_flag_d = 1'b0;
         transfer_active_flag_d = 1'b0;
         receive_full_flag_d = 1'b0;
         transmit_empty_flag_d = 1'b1;
         receive_overrun_flag_d = 1'b0;
         transmit_underrun_flag_d = 1'b0;
         transmit_buffer_d = 8'h00;
         receive_buffer_d = 8'h00;
         shreg_d = 8'h00;
         bitcnt_d = 4'h0;
         drain_d = 4'h0;
         second_read_d = 1'b0;
         irq_pend_d = 1'b0;
         irq_d = 1'b0;
         out_d = 1'b1;
         state_d = st_idle;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_sync_q <= 2'b11;
         si_sync_q <= 2'b11;
         sck_prev_q <= 1'b1;
      end else if (clk_en) begin
         sck_sync_q <= {sck_sync_q[0], serial_clock_pin_i};
         si_sync_q <= {si_sync_q[0], serial_in_line};
         sck_prev_q <= sck_now;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_request_q <= 1'b0;
         bit_order_q <= 1'b0;
         transfer_mode_field_q <= `MODE_TX;
         cksel_q <= 3'h0;
         shift_active_flag_q <= 1'b0;
         transfer_active_flag_q <= 1'b0;
         receive_full_flag_q <= 1'b0;
         transmit_empty_flag_q <= 1'b1;
         receive_overrun_flag_q <= 1'b0;
         transmit_underrun_flag_q <= 1'b0;
         transmit_buffer_q <= 8'h00;
         receive_buffer_q <= 8'h00;
         shreg_q <= 8'h00;
         bitcnt_q <= 4'h0;
         rx_read_q <= 1'b0;
         tx_written_q <= 1'b0;
         second_read_q <= 1'b0;
         drain_q <= 4'h0;
         irq_pend_q <= 1'b0;
         irq_q <= 1'b0;
         out_q <= 1'b1;
         state_q <= st_idle;
         div_q <= 8'h00;
         sck_int_q <= 1'b1;
      end else if (clk_en) begin
         start_request_q <= start_request_d;
         bit_order_q <= bit_order_d;
         transfer_mode_field_q <= transfer_mode_field_d;
         cksel_q <= cksel_d;
         shift_active_flag_q <= shift_active_flag_d;
         transfer_active_flag_q <= transfer_active_flag_d;
         receive_full_flag_q <= receive_full_flag_d;
         transmit_empty_flag_q <= transmit_empty_flag_d;
         receive_overrun_flag_q <= receive_overrun_flag_d;
         transmit_underrun_flag_q <= transmit_underrun_flag_d;
         transmit_buffer_q <= transmit_buffer_d;
         receive_buffer_q <= receive_buffer_d;
         shreg_q <= shreg_d;
         bitcnt_q <= bitcnt_d;
         rx_read_q <= rx_read_d;
         tx_written_q <= tx_written_d;
         second_read_q <= second_read_d;
         drain_q <= drain_d;
         irq_pend_q <= irq_pend_d;
         irq_q <= irq_d;
         out_q <= out_d;
         state_q <= state_d;
         div_q <= div_d;
         sck_int_q <= sck_int_d;
      end
   end
endmodule

// *** pkg/sio_defs.svh ***
`ifndef SIO_DEFS_SVH
`define SIO_DEFS_SVH
// register byte offsets
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define REG_TXBUF 12'h008
`define REG_RXBUF 12'h00C
// control fields
`define CTL_START 0
`define CTL_STOP 1
`define CTL_ORDER 2
`define CTL_MODE_LO 3
`define CTL_CKSEL_LO 5
`define CKSEL_EXT 3'h7
`define MODE_TX 2'h0
`define MODE_RX 2'h1
`define MODE_DUPLEX 2'h2
// status fields
`define ST_SHIFT 0
`define ST_ACTIVE 1
`define ST_RXFULL 2
`define ST_TXEMPTY 3
`define ST_OVERRUN 4
`define ST_UNDERRUN 5
// internal serial clock half period in system cycles
`define HALF_DIV_DEFAULT 8'h08
`endif

// *** pkg/sio_pkg.sv ***
package sio_pkg;
   typedef enum logic [1:0] {st_idle, st_run, st_wait} link_state_e;
endpackage

// *** test/sync_serial_rx_and_duplex_assertions.sv ***
`timescale 1ns/100ps
`include "sio_defs.svh"
module sync_serial_rx_and_duplex_chk (
   // system
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link
   input wire logic serial_clock_pin_i,
   input wire logic serial_clock_pin_o,
   input wire logic serial_clock_pin_oe,
   input wire logic serial_in_line,
   input wire logic serial_out_line,
   input wire logic serial_port_irq
);
   logic [1:0] mode_q;
   logic [1:0] mode_d;
   logic wr_ctl;
   logic rd_stat;
   assign wr_ctl = psel && penable && pwrite && paddr == `REG_CONTROL;
   assign rd_stat = psel && !pwrite && paddr == `REG_STATUS;
   // mode is shadowed from bus writes, the status word does not carry it
   always_comb begin
      mode_d = mode_q;
      if (wr_ctl) begin
         mode_d = pwdata[4:3];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= 2'h0;
      end else begin
         mode_q <= mode_d;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence park_high;
      serial_clock_pin_o [*8];
   endsequence
   sequence byte_done_int;
      serial_port_irq && serial_clock_pin_oe;
   endsequence
   chk_under_out_high: assert property (rd_stat && prdata[`ST_UNDERRUN] |-> serial_out_line)
      else $error("output low while underrun set");
   chk_idle_out_high: assert property (rd_stat && !prdata[`ST_ACTIVE] && mode_q != `MODE_RX
      |-> serial_out_line)
      else $error("output low while stopped");
   chk_ext_oe_off: assert property (wr_ctl && pwdata[7:5] == `CKSEL_EXT |=> !serial_clock_pin_oe)
      else $error("clock driven with external select");
   chk_int_oe_on: assert property (wr_ctl && pwdata[7:5] != `CKSEL_EXT |=> serial_clock_pin_oe)
      else $error("clock not driven with internal select");
   chk_rx_park: assert property ((mode_q == `MODE_RX) ##0 byte_done_int |=> park_high)
      else $error("receive clock not parked");
   chk_duplex_park: assert property ((mode_q == `MODE_DUPLEX) ##0 byte_done_int
      |=> park_high)
      else $error("duplex clock not parked");
   chk_irq_pulse: assert property (serial_port_irq |=> !serial_port_irq)
      else $error("irq longer than one cycle");
   chk_stop_halts: assert property (wr_ctl && pwdata[`CTL_STOP]
      |-> ##2 (serial_out_line && serial_clock_pin_o) [*2])
      else $error("force stop did not halt");
   chk_int_start: assert property (wr_ctl && pwdata[0] && pwdata[4:3] == `MODE_RX
      && pwdata[7:5] != `CKSEL_EXT |-> ##[1:24] !serial_clock_pin_o)
      else $error("internal clock late");
   chk_mode_quiet: assert property (wr_ctl && pwdata[4:3] == 2'h3
      |=> (serial_clock_pin_o && !serial_port_irq) [*8])
      else $error("activity in unused mode");
endmodule
bind sync_serial_rx_and_duplex sync_serial_rx_and_duplex_chk u_chk (.clk(clk), .rst_n(rst_n),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_clock_pin_i(serial_clock_pin_i), .serial_clock_pin_o(serial_clock_pin_o),
   .serial_clock_pin_oe(serial_clock_pin_oe), .serial_in_line(serial_in_line),
   .serial_out_line(serial_out_line), .serial_port_irq(serial_port_irq));

// *** test/sio_peer.sv ***
`timescale 1ns/100ps
module sio_peer (
   // link
   input wire logic pin,
   input wire logic so,
   output logic sck_drv,
   output logic sdi,
   // bench side
   input wire logic go,
   input wire logic rewind,
   input wire logic [7:0] send_byte,
   output logic [7:0] got_byte,
   output logic busy
);
   int idx;
   initial begin
      sck_drv = 1'b1;
      sdi = 1'b1;
      got_byte = 8'h00;
      busy = 1'b0;
      idx = 0;
   end
   // clock stands high outside a frame, 125 ns period inside
   always @(posedge go) begin
      busy = 1'b1;
      repeat (8) begin
         #62.5 sck_drv = 1'b0;
         #62.5 sck_drv = 1'b1;
      end
      busy = 1'b0;
   end
   always @(posedge rewind) idx = 0;
   // wire order is msb of send_byte first; drive on fall, sample on rise
   always @(negedge pin) sdi = send_byte[7 - idx];
   always @(posedge pin) begin
      got_byte = {got_byte[6:0], so};
      idx = (idx + 1) % 8;
      // hold over: inverse so a stale bit is never mistaken for data
      #40 sdi = ~sdi;
   end
endmodule

// *** test/test_sync_serial_rx_and_duplex.sv ***
`timescale 1ns/100ps
`include "sio_defs.svh"
module test_sync_serial_rx_and_duplex;
   logic clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic sck_o, sck_oe, sck_drv, pin, sdi, sdo, irq, go, rewind, busy;
   logic [7:0] send_byte, got_byte;
   int mismatches, checks_done, irq_seen, n;
   assign pin = sck_oe ? sck_o : sck_drv;
   sync_serial_rx_and_duplex u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_clock_pin_i(pin),
      .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe), .serial_in_line(sdi),
      .serial_out_line(sdo), .serial_port_irq(irq));
   sio_peer u_peer (.pin(pin), .so(sdo), .sck_drv(sck_drv), .sdi(sdi), .go(go),
      .rewind(rewind), .send_byte(send_byte), .got_byte(got_byte), .busy(busy));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (irq === 1'b1) irq_seen++;
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic timeout(input int k, input int lim);
      if (k >= lim) begin
         mismatches++;
         final_report();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         rdata = prdata;
         k++;
      end while (pready !== 1'b1 && k < 20);
      timeout(k, 20);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [31:0] ctl(input logic o, input logic [1:0] m, input logic [2:0] c,
      input logic s);
      return {24'h0, c, m, o, 1'b0, s};
   endfunction
   task automatic wait_irq();
      int k, n0;
      k = 0;
      n0 = irq_seen;
      while (irq_seen == n0 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      timeout(k, 2000);
      repeat (40) @(posedge clk);
   endtask
   task automatic peer_byte(input logic [7:0] b);
      int k;
      k = 0;
      send_byte <= b;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do begin
         @(posedge clk);
         k++;
      end while (busy && k < 300);
      timeout(k, 300);
      repeat (10) @(posedge clk);
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         apb(1'b0, `REG_STATUS, 32'h0);
         k++;
      end while (rdata[`ST_ACTIVE] && k < 60);
      check("active cleared", 0, rdata[`ST_ACTIVE]);
   endtask
   task automatic stop_all();
      apb(1'b1, `REG_CONTROL, 32'h2);
      rewind <= 1'b1;
      @(posedge clk);
      rewind <= 1'b0;
   endtask
   initial begin
      {rst_n, psel, penable, pwrite, go, rewind, paddr, pwdata} = '0;
      {clk_en, send_byte} = 9'h1FF;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int o = 0; o < 2; o++) begin
         stop_all();
         send_byte <= 8'h1D;
         apb(1'b1, `REG_CONTROL, ctl(o[0], `MODE_RX, 3'h0, 1'b1));
         wait_irq();
         check("clock parked", 1, sck_o);
         apb(1'b0, `REG_STATUS, 32'h0);
         check("rx full", 1, rdata[`ST_RXFULL]);
         check("active", 1, rdata[`ST_ACTIVE]);
         apb(1'b0, `REG_RXBUF, 32'h0);
         check("rx byte", o ? 8'hB8 : 8'h1D, rdata[7:0]);
         apb(1'b0, `REG_STATUS, 32'h0);
         check("rx full clear", 0, rdata[`ST_RXFULL]);
         wait_irq();
         $display("test internal receive order %0d done", o);
      end
      stop_all();
      send_byte <= 8'hC6;
      apb(1'b1, `REG_TXBUF, 32'h96);
      apb(1'b0, `REG_STATUS, 32'h0);
      check("tx empty clear", 0, rdata[`ST_TXEMPTY]);
      apb(1'b1, `REG_CONTROL, ctl(1'b0, `MODE_DUPLEX, 3'h0, 1'b1));
      wait_irq();
      apb(1'b0, `REG_STATUS, 32'h0);
      check("duplex flags", 3, {rdata[`ST_RXFULL], rdata[`ST_TXEMPTY]});
      check("peer got", 8'h96, got_byte);
      apb(1'b0, `REG_RXBUF, 32'h0);
      check("duplex rx", 8'hC6, rdata[7:0]);
      repeat (40) @(posedge clk);
      check("parked on read only", 1, sck_o);
      apb(1'b1, `REG_TXBUF, 32'h69);
      wait_irq();
      check("peer got 2", 8'h69, got_byte);
      apb(1'b1, `REG_CONTROL, ctl(1'b0, `MODE_DUPLEX, 3'h0, 1'b0));
      wait_idle();
      check("out high", 1, sdo);
      $display("test duplex done");
      stop_all();
      apb(1'b1, `REG_CONTROL, ctl(1'b0, `MODE_RX, `CKSEL_EXT, 1'b1));
      n = irq_seen;
      peer_byte(8'h5A);
      check("irq byte", n + 1, irq_seen);
      peer_byte(8'hC3);
      check("irq overrun", n + 2, irq_seen);
      apb(1'b0, `REG_STATUS, 32'h0);
      check("overrun", 1, rdata[`ST_OVERRUN]);
      peer_byte(8'hE1);
      check("irq held off", n + 2, irq_seen);
      apb(1'b1, `REG_CONTROL, ctl(1'b0, `MODE_RX, `CKSEL_EXT, 1'b0));
      peer_byte(8'h0F);
      wait_idle();
      apb(1'b0, `REG_RXBUF, 32'h0);
      check("first read", 8'h5A, rdata[7:0]);
      apb(1'b0, `REG_RXBUF, 32'h0);
      check("second read", 8'hC3, rdata[7:0]);
      apb(1'b1, `REG_STATUS, 32'h0);
      apb(1'b0, `REG_STATUS, 32'h0);
      check("overrun cleared", 0, rdata & 32'h14);
      $display("test overrun done");
      stop_all();
      apb(1'b1, `REG_TXBUF, 32'hA5);
      apb(1'b1, `REG_CONTROL, ctl(1'b0, `MODE_DUPLEX, `CKSEL_EXT, 1'b1));
      peer_byte(8'h3C);
      check("ext duplex tx 1", 8'hA5, got_byte);
      apb(1'b0, `REG_RXBUF, 32'h0);
      check("ext duplex rx 1", 8'h3C, rdata[7:0]);
      apb(1'b1, `REG_TXBUF, 32'h5A);
      peer_byte(8'h81);
      check("ext duplex tx 2", 8'h5A, got_byte);
      apb(1'b0, `REG_RXBUF, 32'h0);
      check("ext duplex rx 2", 8'h81, rdata[7:0]);
      stop_all();
      $display("test external duplex done");
      apb(1'b1, `REG_CONTROL, ctl(1'b0, `MODE_TX, `CKSEL_EXT, 1'b1));
      n = irq_seen;
      peer_byte(8'h00);
      check("irq underrun", n + 1, irq_seen);
      apb(1'b0, `REG_STATUS, 32'h0);
      check("underrun", 1, rdata[`ST_UNDERRUN]);
      check("line high", 8'hFF, got_byte);
      stop_all();
      apb(1'b0, `REG_STATUS, 32'h0);
      check("status init", 0, rdata & 32'h37);
      apb(1'b0, `REG_RXBUF, 32'h0);
      check("rx init", 0, rdata);
      $display("test underrun done");
      n = irq_seen;
      apb(1'b1, `REG_CONTROL, ctl(1'b0, 2'h3, 3'h0, 1'b1));
      repeat (300) @(posedge clk);
      check("mode 11 idle", {1'b1, n[7:0]}, {sck_o, irq_seen[7:0]});
      check("no slave error", 0, pslverr);
      $display("test unused mode done");
      final_report();
   end
endmodule
